// ---- common/uslc_pkg.sv ----
// Shared constants, register map and carrier types for the USB-UART line control
package uslc_pkg;
   // Register word indices (byte address = index * 4)
   localparam logic [3:0] USLC_REG_CTRL    = 4'h0;
   localparam logic [3:0] USLC_REG_DIVISOR = 4'h1;
   localparam logic [3:0] USLC_REG_TIMEOUT = 4'h2;
   localparam logic [3:0] USLC_REG_INVERT  = 4'h3;
   localparam logic [3:0] USLC_REG_AUX     = 4'h4;
   localparam logic [3:0] USLC_REG_STATUS  = 4'h5;
   localparam logic [3:0] USLC_REG_ID      = 4'h6;
   // Control register bit positions
   localparam int USLC_CTRL_BITBANG = 0;
   localparam int USLC_CTRL_POWER   = 1;
   localparam int USLC_CTRL_BLEED   = 2;
   // Divisor field layout
   localparam int USLC_DIV_N_LSB    = 0;
   localparam int USLC_DIV_N_W      = 14;
   localparam int USLC_DIV_F_LSB    = 14;
   localparam int USLC_DIV_F_W      = 3;
   // Aux register layout
   localparam int USLC_AUX_OUT_LSB  = 0;
   localparam int USLC_AUX_DIR_LSB  = 4;
   // Status register layout
   localparam int USLC_ST_AUX_LSB   = 0;
   localparam int USLC_ST_LINE_LSB  = 4;
   localparam int USLC_ST_PEND      = 12;
   // Serial line indices
   localparam int USLC_L_TXD = 0;
   localparam int USLC_L_RXD = 1;
   localparam int USLC_L_RTS = 2;
   localparam int USLC_L_CTS = 3;
   localparam int USLC_L_DTR = 4;
   localparam int USLC_L_DSR = 5;
   localparam int USLC_L_DCD = 6;
   localparam int USLC_L_RI  = 7;
   // Baud reference: 3 MHz over a divisor counted in eighths
   localparam int USLC_REF_HZ      = 3000000;
   localparam int USLC_CLK_HZ      = 50000000;
   localparam int USLC_CLK_MHZ     = USLC_CLK_HZ / 1000000;
   localparam int USLC_EIGHTHS     = 8;
   localparam logic [23:0] USLC_ACC_STEP = 24'(USLC_REF_HZ / 1000000 * USLC_EIGHTHS);
   localparam logic [14:0] USLC_N_MAX    = 15'h4000;
   localparam logic [13:0] USLC_N_ONE    = 14'h0001;
   // Reset values
   localparam logic [13:0] USLC_DIV_N_RST = 14'h0010;
   localparam logic [2:0]  USLC_DIV_F_RST = 3'h0;
   localparam logic [7:0]  USLC_TMO_RST   = 8'h10;
   localparam logic [7:0]  USLC_TMO_MIN   = 8'h01;
   // Timeout step: one millisecond in clock cycles
   localparam int USLC_MS_NS      = 1000000;
   localparam int USLC_CLK_NS     = 20;
   localparam int USLC_CYC_PER_MS = USLC_MS_NS / USLC_CLK_NS;

   // Baud divisor as software programs it
   typedef struct packed {
      logic [2:0]  frac;
      logic [13:0] n;
   } uslc_div_s;

   // Control bits
   typedef struct packed {
      logic bleed_en;
      logic power_on;
      logic bitbang_en;
   } uslc_ctrl_s;
endpackage

// ---- core/uslc_buf2.sv ----
// Two-entry valid/ready buffer with registered handshake outputs
`timescale 1ns/100ps
module uslc_buf2 #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             clear,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   logic [WIDTH-1:0] mem_reg [2];     // Storage, entry 0 is head
   logic [WIDTH-1:0] mem_next [2];
   logic [1:0]       cnt_reg;         // Words held
   logic [1:0]       cnt_next;
   logic             push;
   logic             pop;

   // Handshakes come straight from the count register
   assign in_ready  = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data  = mem_reg[0];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next state: shift head out on pop, append at tail on push
   always_comb begin
      mem_next[0] = mem_reg[0];
      mem_next[1] = mem_reg[1];
      cnt_next    = cnt_reg;
      if (clear) begin
         cnt_next = 2'h0;
      end else begin
         if (pop) begin
            mem_next[0] = mem_reg[1];
         end
         if (push) begin
            // Tail slot depends on whether head left this cycle
            if ((cnt_reg - (pop ? 2'h1 : 2'h0)) == 2'h0) begin
               mem_next[0] = in_data;
            end else begin
               mem_next[1] = in_data;
            end
         end
         cnt_next = cnt_reg + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
      end
   end

   // Registers only
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         cnt_reg    <= 2'h0;
      end else begin
         mem_reg[0] <= mem_next[0];
         mem_reg[1] <= mem_next[1];
         cnt_reg    <= cnt_next;
      end
   end
endmodule // uslc_buf2

// ---- core/uslc_line_ctrl.sv ----
// Line control of a USB-to-serial bridge: baud, flush timeout, inversion, aux pins
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
module uslc_line_ctrl import uslc_pkg::*; #(
   parameter int          CYC_PER_MS           = USLC_CYC_PER_MS,
   parameter logic [31:0] UNIQUE_DEVICE_NUMBER = 32'h5A5A_1234  // Arbitrary value
) (
   // Clock and resets
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ext_reset_n,
   // Avalon-MM register slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Receive byte stream from the serial receiver
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [7:0]  rx_data,
   // Byte stream toward the USB side
   output logic             host_valid,
   input  wire logic        host_ready,
   output logic [7:0]       host_data,
   output logic             host_flush,
   // Bit-rate tick for the serial engine
   output logic             baud_tick,
   // Serial engine side, true sense
   input  wire logic        core_txd,
   input  wire logic        core_rts_n,
   input  wire logic        core_dtr_n,
   output logic [7:0]       core_lines_in,
   // Serial pins, possibly inverted
   input  wire logic [7:0]  line_pin_in,
   output logic [7:0]       line_pin_out,
   output logic [7:0]       line_pull_down,
   // Auxiliary control pins
   input  wire logic [3:0]  aux_control_pins_in,
   output logic [3:0]       aux_control_pins_out,
   output logic [3:0]       aux_control_pins_oe,
   // External power switch, low enables power
   output logic             ext_power_switch_n
);
   // Register file state
   uslc_ctrl_s  ctrl_reg, ctrl_next;           // Mode and power bits
   uslc_div_s   div_reg, div_next;             // Baud divisor
   logic [7:0]  tmo_reg, tmo_next;             // Flush timeout in ms
   logic [7:0]  inv_reg, inv_next;             // Per-line inversion mask
   logic [3:0]  aux_out_reg, aux_out_next;     // Aux output values
   logic [3:0]  aux_dir_reg, aux_dir_next;     // Aux direction, 1 drives
   logic        wait_reg, wait_next;           // Bus waitrequest
   logic [31:0] rdata_reg, rdata_next;         // Read answer
   // Baud state
   logic [23:0] acc_reg, acc_next;             // Fractional accumulator
   logic        tick_reg, tick_next;
   logic [23:0] limit;                         // Divisor in eighths times clock MHz
   logic [14:0] n_eff;
   logic [2:0]  f_eff;
   // Timeout state
   logic [15:0] ms_cnt_reg, ms_cnt_next;       // Cycles within current ms
   logic [7:0]  ms_left_reg, ms_left_next;     // Whole ms still to wait
   logic        flush_reg, flush_next;
   // Pin state
   logic [7:0]  pin_out_reg, pin_out_next;
   logic [7:0]  lines_in_reg, lines_in_next;
   logic [7:0]  pull_reg, pull_next;
   logic [3:0]  aux_in_reg, aux_in_next;
   logic [3:0]  aux_oe_reg, aux_oe_next;
   logic        pwr_n_reg, pwr_n_next;
   // Misc
   logic        soft_rst;                      // External reset, taken synchronously
   logic        wr_take;
   logic        rd_take;
   logic        rx_push;

   assign soft_rst = !ext_reset_n;
   assign wr_take  = avs_write && !wait_reg;
   assign rd_take  = avs_read && !wait_reg;
   assign rx_push  = rx_valid && rx_ready;

   // Receive path buffer; a stalled host simply backs up into rx_ready
   uslc_buf2 #(
      .WIDTH     (8)
   ) u_rxbuf (
      .clk       (clk),
      .reset_n   (reset_n),
      .clear     (soft_rst),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   (rx_data),
      .out_valid (host_valid),
      .out_ready (host_ready),
      .out_data  (host_data)
   );

   // Bus and register file: one wait cycle, then a one-cycle answer
   always_comb begin
      ctrl_next    = ctrl_reg;
      div_next     = div_reg;
      tmo_next     = tmo_reg;
      inv_next     = inv_reg;
      aux_out_next = aux_out_reg;
      aux_dir_next = aux_dir_reg;
      rdata_next   = rdata_reg;
      // Drop wait for exactly one cycle per request
      wait_next    = !((avs_read || avs_write) && wait_reg);
      if (soft_rst) begin
         ctrl_next    = '0;
         div_next     = '{frac: USLC_DIV_F_RST, n: USLC_DIV_N_RST};
         tmo_next     = USLC_TMO_RST;
         inv_next     = '0;
         aux_out_next = '0;
         aux_dir_next = '0;
         wait_next    = 1'b1;
      end else if (wr_take) begin
         case (avs_address)
            USLC_REG_CTRL: begin
               ctrl_next = avs_writedata[USLC_CTRL_BLEED:USLC_CTRL_BITBANG];
            end
            USLC_REG_DIVISOR: begin
               div_next.n    = avs_writedata[USLC_DIV_N_LSB +: USLC_DIV_N_W];
               div_next.frac = avs_writedata[USLC_DIV_F_LSB +: USLC_DIV_F_W];
            end
            USLC_REG_TIMEOUT: begin
               // Zero is not a legal timeout; clamp to the shortest
               tmo_next = (avs_writedata[7:0] == 8'h00) ? USLC_TMO_MIN
                                                       : avs_writedata[7:0];
            end
            USLC_REG_INVERT: begin
               inv_next = avs_writedata[7:0];
            end
            USLC_REG_AUX: begin
               aux_out_next = avs_writedata[USLC_AUX_OUT_LSB +: 4];
               aux_dir_next = avs_writedata[USLC_AUX_DIR_LSB +: 4];
            end
            default: begin
               // Read-only or unmapped: write ignored
            end
         endcase
      end
      // Load read data while the request waits
      if (avs_read && wait_reg) begin
         case (avs_address)
            USLC_REG_CTRL:    rdata_next = {29'h0, ctrl_reg};
            USLC_REG_DIVISOR: rdata_next = {15'h0, div_reg};
            USLC_REG_TIMEOUT: rdata_next = {24'h0, tmo_reg};
            USLC_REG_INVERT:  rdata_next = {24'h0, inv_reg};
            USLC_REG_AUX:     rdata_next = {24'h0, aux_dir_reg, aux_out_reg};
            USLC_REG_STATUS:  rdata_next = {19'h0, host_valid, lines_in_reg[7:0],
                                            aux_in_reg};
            USLC_REG_ID:      rdata_next = UNIQUE_DEVICE_NUMBER;
            default:          rdata_next = 32'h0;
         endcase
      end
   end

   // Register file flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg    <= '0;
         div_reg     <= '{frac: USLC_DIV_F_RST, n: USLC_DIV_N_RST};
         tmo_reg     <= USLC_TMO_RST;
         inv_reg     <= '0;
         aux_out_reg <= '0;
         aux_dir_reg <= '0;
         wait_reg    <= 1'b1;
         rdata_reg   <= '0;
      end else begin
         ctrl_reg    <= ctrl_next;
         div_reg     <= div_next;
         tmo_reg     <= tmo_next;
         inv_reg     <= inv_next;
         aux_out_reg <= aux_out_next;
         aux_dir_reg <= aux_dir_next;
         wait_reg    <= wait_next;
         rdata_reg   <= rdata_next;
      end
   end

   // Effective divisor: field zero means 16384, n of one drops the fraction
   always_comb begin
      n_eff = (div_reg.n == '0) ? USLC_N_MAX : {1'b0, div_reg.n};
      f_eff = (div_reg.n == USLC_N_ONE) ? 3'h0 : div_reg.frac;
      limit = 24'(({9'h0, n_eff} * 24'(USLC_EIGHTHS) + {21'h0, f_eff})
                  * 24'(USLC_CLK_MHZ));
   end

   // Baud accumulator: adds 3 MHz in eighths per clock, ticks on overflow
   always_comb begin
      acc_next  = acc_reg + USLC_ACC_STEP;
      tick_next = 1'b0;
      if (soft_rst) begin
         acc_next = '0;
      end else if (acc_next >= limit) begin
         // Remainder kept so fractional divisors average exactly
         acc_next  = acc_next - limit;
         tick_next = 1'b1;
         if (acc_next >= limit) acc_next = '0;  // Divisor just shrank: no tick burst
      end
   end

   // Baud flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         tick_reg <= tick_next;
      end
   end

   // Flush timer: restarts on every new byte, runs only while data waits
   always_comb begin
      ms_cnt_next  = ms_cnt_reg;
      ms_left_next = ms_left_reg;
      flush_next   = 1'b0;
      if (soft_rst || rx_push || !host_valid) begin
         ms_cnt_next  = '0;
         ms_left_next = tmo_reg;
      end else if (ms_cnt_reg == 16'(CYC_PER_MS - 1)) begin
         ms_cnt_next = '0;
         if (ms_left_reg <= USLC_TMO_MIN) begin
            flush_next   = 1'b1;
            ms_left_next = tmo_reg;
         end else begin
            ms_left_next = ms_left_reg - 8'h01;
         end
      end else begin
         ms_cnt_next = ms_cnt_reg + 16'h0001;
      end
   end

   // Flush timer flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_cnt_reg  <= '0;
         ms_left_reg <= USLC_TMO_RST;
         flush_reg   <= 1'b0;
      end else begin
         ms_cnt_reg  <= ms_cnt_next;
         ms_left_reg <= ms_left_next;
         flush_reg   <= flush_next;
      end
   end

   // Pins: inversion, bleed-down, aux port and power switch
   always_comb begin
      // Outgoing lines carry the engine's sense xor the mask
      pin_out_next                = '0;
      pin_out_next[USLC_L_TXD]    = core_txd ^ inv_reg[USLC_L_TXD];
      pin_out_next[USLC_L_RTS]    = core_rts_n ^ inv_reg[USLC_L_RTS];
      pin_out_next[USLC_L_DTR]    = core_dtr_n ^ inv_reg[USLC_L_DTR];
      // Incoming lines restored to true sense; output slots also give line_pin_in xor the mask
      lines_in_next               = line_pin_in ^ inv_reg;
      // Weak pull only with option set and power switched off
      pull_next   = {8{ctrl_reg.bleed_en && !ctrl_reg.power_on}};
      pwr_n_next  = !ctrl_reg.power_on;
      // Aux port is separate from the serial path, so both run at once
      aux_in_next = aux_control_pins_in;
      aux_oe_next = ctrl_reg.bitbang_en ? aux_dir_reg : 4'h0;
      if (soft_rst) begin
         pull_next   = '0;
         pwr_n_next  = 1'b1;
         aux_oe_next = '0;
      end
   end

   // Pin flops; power stays off out of reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out_reg  <= '0;
         lines_in_reg <= '0;
         pull_reg     <= '0;
         aux_in_reg   <= '0;
         aux_oe_reg   <= '0;
         pwr_n_reg    <= 1'b1;
      end else begin
         pin_out_reg  <= pin_out_next;
         lines_in_reg <= lines_in_next;
         pull_reg     <= pull_next;
         aux_in_reg   <= aux_in_next;
         aux_oe_reg   <= aux_oe_next;
         pwr_n_reg    <= pwr_n_next;
      end
   end

   // Output assignments
   assign avs_readdata         = rdata_reg;
   assign avs_waitrequest      = wait_reg;
   assign host_flush           = flush_reg;
   assign baud_tick            = tick_reg;
   assign core_lines_in        = lines_in_reg;
   assign line_pin_out         = pin_out_reg;
   assign line_pull_down       = pull_reg;
   assign aux_control_pins_out = aux_out_reg;
   assign aux_control_pins_oe  = aux_oe_reg;
   assign ext_power_switch_n   = pwr_n_reg;
endmodule // uslc_line_ctrl

// ---- tb/uslc_line_ctrl_sva.sv ----
// Port-level assertions for the line-control block
`timescale 1ns/100ps
module uslc_line_ctrl_sva import uslc_pkg::*; (
   // Clock and resets
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ext_reset_n,
   // Register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   // Streams
   input wire logic        rx_valid,
   input wire logic        rx_ready,
   input wire logic        host_valid,
   input wire logic        host_flush,
   input wire logic        baud_tick,
   // Pins
   input wire logic [7:0]  line_pin_out,
   input wire logic [7:0]  line_pull_down,
   input wire logic [3:0]  aux_control_pins_out,
   input wire logic [3:0]  aux_control_pins_oe,
   input wire logic        ext_power_switch_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Accepted writes
   wire ctrl_wr = avs_write && !avs_waitrequest && avs_address == USLC_REG_CTRL;
   wire aux_wr  = avs_write && !avs_waitrequest && avs_address == USLC_REG_AUX;

   property p_bus_answer;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("Bus answer late");
   property p_power;
      ctrl_wr |-> ##2 (ext_power_switch_n == !$past(avs_writedata[USLC_CTRL_POWER], 2));
   endproperty
   a_power: assert property (p_power) else $error("Power switch wrong");
   property p_bleed;
      ctrl_wr |-> ##2 (line_pull_down == {8{$past(avs_writedata[2] & ~avs_writedata[1], 2)}});
   endproperty
   a_bleed: assert property (p_bleed) else $error("Pull-down wrong");
   property p_aux_out;
      aux_wr |-> ##2 (aux_control_pins_out == $past(avs_writedata[3:0], 2));
   endproperty
   a_aux_out: assert property (p_aux_out) else $error("Aux outputs wrong");
   property p_flush_data;
      host_flush |-> $past(host_valid);
   endproperty
   a_flush_data: assert property (p_flush_data) else $error("Flush with empty buffer");
   property p_flush_pulse;
      host_flush |=> !host_flush [*8];
   endproperty
   a_flush_pulse: assert property (p_flush_pulse) else $error("Flush pulses too close");
   property p_tick_gap;
      baud_tick |=> !baud_tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("Bit ticks too close");
   property p_rx_first;
      rx_valid && rx_ready && !host_valid |=> host_valid;
   endproperty
   a_rx_first: assert property (p_rx_first) else $error("Pushed byte not offered");
   property p_unused_pins;
      (line_pin_out & 8'hEA) == 8'h00;
   endproperty
   a_unused_pins: assert property (p_unused_pins) else $error("Input-only pin driven");
   property p_ext_reset;
      !ext_reset_n |-> ##2 (ext_power_switch_n && line_pull_down == 8'h00
                            && aux_control_pins_oe == 4'h0);
   endproperty
   a_ext_reset: assert property (p_ext_reset) else $error("Ext reset missed");
endmodule // uslc_line_ctrl_sva

bind uslc_line_ctrl uslc_line_ctrl_sva u_sva (
   .clk, .reset_n, .ext_reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_waitrequest, .rx_valid, .rx_ready, .host_valid, .host_flush, .baud_tick,
   .line_pin_out, .line_pull_down, .aux_control_pins_out, .aux_control_pins_oe,
   .ext_power_switch_n
);

// ---- tb/uslc_host_model.sv ----
// USB host side model: drains the byte stream and logs flushes
`timescale 1ns/100ps
module uslc_host_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Stream from the bridge
   input  wire logic       host_valid,
   input  wire logic [7:0] host_data,
   input  wire logic       host_flush,
   output logic            host_ready,
   // High stalls the host
   input  wire logic       stall
);
   logic [7:0] got [0:15];  // Bytes in arrival order
   int         got_n;       // Bytes taken
   int         flush_n;     // Flush pulses seen

   // Ready lags stall by a cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_ready <= 1'b0;
         got_n      <= 0;
         flush_n    <= 0;
      end else begin
         host_ready <= !stall;
         if (host_valid && host_ready) begin
            got[got_n[3:0]] <= host_data;
            got_n           <= got_n + 1;
         end
         if (host_flush) begin
            flush_n <= flush_n + 1;
         end
      end
   end
endmodule // uslc_host_model

// ---- tb/uslc_line_ctrl_test.sv ----
// Self-checking bench for the line-control block
`timescale 1ns/100ps
module uslc_line_ctrl_test import uslc_pkg::*;;
   localparam int          CPM    = 10;             // Shortened millisecond
   localparam logic [31:0] DEV_ID = 32'hC0DE_0042;  // Arbitrary value
   logic clk, reset_n, ext_reset_n, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address, aux_in, aux_out, aux_oe;
   logic [31:0] avs_writedata, avs_readdata, rv;
   logic rx_valid, rx_ready, host_valid, host_ready, host_flush, baud_tick, pwr_n, stall;
   logic [7:0] rx_data, host_data, lines_in, pin_in, pin_out, pull;
   logic core_txd, core_rts_n, core_dtr_n;
   int fail_count, n_compared;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   uslc_line_ctrl #(.CYC_PER_MS(CPM), .UNIQUE_DEVICE_NUMBER(DEV_ID)) u_dut (
      .clk, .reset_n, .ext_reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .rx_valid, .rx_ready, .rx_data, .host_valid,
      .host_ready, .host_data, .host_flush, .baud_tick, .core_txd, .core_rts_n,
      .core_dtr_n, .core_lines_in(lines_in), .line_pin_in(pin_in), .line_pin_out(pin_out),
      .line_pull_down(pull), .aux_control_pins_in(aux_in), .aux_control_pins_out(aux_out),
      .aux_control_pins_oe(aux_oe), .ext_power_switch_n(pwr_n));

   uslc_host_model u_host (.clk, .reset_n, .host_valid, .host_data, .host_flush, .host_ready,
      .stall);

   // Verdict and end of run
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic in_range(input string nm, input int v, input int lo, input int hi);
      check(nm, 32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
   endtask

   // A wait that ran out ends the run
   task automatic hang(input string nm);
      fail_count++;
      $display("BAD %s expected done seen hang", nm);
      test_done();
   endtask

   // One bus access; holds until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 40);
      if (k >= 40) hang("bus");
      rv = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);  // Gap before the next request
   endtask

   task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(nm, rv, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic push(input logic [7:0] b);
      int k;
      k = 0;
      rx_valid <= 1'b1;
      rx_data  <= b;
      do begin
         @(posedge clk);
         k++;
      end while (rx_ready !== 1'b1 && k < 40);
      if (k >= 40) hang("push");
      rx_valid <= 1'b0;
      @(posedge clk);
   endtask

   // Cycles until the next pulse of a chosen output
   task automatic wait_pulse(input logic fl, inout int c);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         c++;
         k++;
      end while ((fl ? host_flush : baud_tick) !== 1'b1 && k < 3000);
      if (k >= 3000) hang("pulse");
   endtask

   // 24 bit periods last (8n+f)*50 clocks on average
   task automatic baud(input logic [13:0] n, input logic [2:0] f, input int e);
      int c;
      c = 0;
      bus(1'b1, USLC_REG_DIVISOR, {15'h0, f, n});
      wait_pulse(1'b0, c);
      wait_pulse(1'b0, c);
      c = 0;
      repeat (24) wait_pulse(1'b0, c);
      in_range("baud span", c, e - 1, e + 1);
   endtask

   task automatic t_reset;
      rdchk("ctrl", USLC_REG_CTRL, 32'h0);
      rdchk("divisor", USLC_REG_DIVISOR, 32'h10);
      rdchk("timeout", USLC_REG_TIMEOUT, 32'h10);
      rdchk("unmapped", 4'hF, 32'h0);
      check("power off", 32'(pwr_n), 32'h1);
      bus(1'b1, USLC_REG_ID, ~DEV_ID);
      rdchk("device number", USLC_REG_ID, DEV_ID);
   endtask

   task automatic t_baud;
      for (int f = 0; f < 8; f++) baud(14'h2, 3'(f), (16 + f) * 50);
      baud(14'h3, 3'h4, 1400);
      rdchk("divisor rb", USLC_REG_DIVISOR, 32'h1_0003);
      baud(14'h1, 3'h5, 400);
      baud(14'h1, 3'h0, 400);
   endtask

   // Stalled host: refusal, timer restart, flush period, drain
   task automatic t_flush;
      int c, fl;
      bus(1'b1, USLC_REG_TIMEOUT, 32'h3);
      stall <= 1'b1;
      cyc(3);
      push(8'hA1);
      cyc(20);
      push(8'hA2);
      c = 1;
      check("rx refused", 32'(rx_ready), 32'h0);
      wait_pulse(1'b1, c);
      in_range("flush delay", c, 3 * CPM, 3 * CPM + 2);
      c = 0;
      wait_pulse(1'b1, c);
      in_range("flush period", c, 3 * CPM - 1, 3 * CPM + 1);
      stall <= 1'b0;
      cyc(8);
      check("drained", 32'(u_host.got_n), 32'h2);
      check("byte 0", 32'(u_host.got[0]), 32'hA1);
      check("byte 1", 32'(u_host.got[1]), 32'hA2);
      fl = u_host.flush_n;
      cyc(100);
      check("no empty flush", 32'(u_host.flush_n), 32'(fl));
      bus(1'b1, USLC_REG_TIMEOUT, 32'h0);
      rdchk("timeout min", USLC_REG_TIMEOUT, 32'h1);
      bus(1'b1, USLC_REG_TIMEOUT, 32'hFF);
      rdchk("timeout max", USLC_REG_TIMEOUT, 32'hFF);
   endtask

   task automatic t_invert(input logic [7:0] m);
      logic [7:0] e;
      e = {3'h0, ~m[4], 1'b0, m[2], 1'b0, ~m[0]};
      bus(1'b1, USLC_REG_INVERT, {24'h0, m});
      core_txd   <= 1'b1;
      core_rts_n <= 1'b0;
      core_dtr_n <= 1'b1;
      pin_in     <= 8'h3C;
      cyc(4);
      check("pins out", 32'(pin_out), 32'(e & 8'h15));
      check("lines in", 32'(lines_in), 32'(8'h3C ^ m));
      rdchk("status lines", USLC_REG_STATUS, {20'h0, 8'h3C ^ m, 4'h0});
   endtask

   task automatic t_aux;
      bus(1'b1, USLC_REG_CTRL, 32'h1);
      bus(1'b1, USLC_REG_AUX, 32'hA6);
      aux_in <= 4'h9;
      push(8'hB7);
      cyc(4);
      check("aux oe", 32'(aux_oe), 32'hA);
      check("aux out", 32'(aux_out), 32'h6);
      check("serial alongside", 32'(u_host.got[2]), 32'hB7);
      rdchk("aux in", USLC_REG_STATUS, {20'h0, 8'h3C ^ 8'h5A, 4'h9});
      bus(1'b1, USLC_REG_CTRL, 32'h4);
      cyc(2);
      check("aux off", 32'(aux_oe), 32'h0);
      check("bleed", 32'(pull), 32'hFF);
      check("power off", 32'(pwr_n), 32'h1);
      bus(1'b1, USLC_REG_CTRL, 32'h6);
      cyc(2);
      check("no bleed", 32'(pull), 32'h0);
      check("power on", 32'(pwr_n), 32'h0);
   endtask

   task automatic t_ext_reset;
      bus(1'b1, USLC_REG_TIMEOUT, 32'h5);
      ext_reset_n <= 1'b0;
      cyc(2);
      ext_reset_n <= 1'b1;
      cyc(2);
      rdchk("ext timeout", USLC_REG_TIMEOUT, 32'h10);
      rdchk("ext divisor", USLC_REG_DIVISOR, 32'h10);
      check("ext power", 32'(pwr_n), 32'h1);
   endtask

   // Main sequence
   initial begin
      {reset_n, avs_read, avs_write, rx_valid, stall, core_txd, core_rts_n} = '0;
      {ext_reset_n, core_dtr_n} = 2'h3;
      {avs_address, avs_writedata, rx_data, pin_in, aux_in} = '0;
      {fail_count, n_compared} = '0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_baud();
      t_flush();
      t_invert(8'hA5);
      t_invert(8'h5A);
      t_aux();
      t_ext_reset();
      test_done();
   end
endmodule // uslc_line_ctrl_test
